// File: core/sel_clk_pkg.sv
/*
 Package for the serial select/clock front end: field widths, timing constants,
 reset values and state and command types.
 Assumes a 250 MHz ref_clk; nothing else.
*/
package sel_clk_pkg;
   // Core clock period in picoseconds (4 ns)
   localparam int unsigned CLK_PERIOD_PS      = 4000;
   // Least deselect interval, in nanoseconds
   localparam int unsigned DESELECT_MIN_NS    = 1000;
   // Least deselect interval in core cycles, rounded up
   localparam int unsigned DESELECT_MIN_CYC   =
      (DESELECT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Width of the deselect counter
   localparam int unsigned DESEL_CNT_W        = 9;
   // Opcode field width
   localparam int unsigned OPCODE_W           = 2;
   // Address field lengths for each word width
   localparam int unsigned ADDR_LEN_X16       = 8;
   localparam int unsigned ADDR_LEN_X8        = 9;
   // Data word lengths for each word width
   localparam int unsigned DATA_LEN_X16       = 16;
   localparam int unsigned DATA_LEN_X8        = 8;
   // Width of the in-frame bit counter
   localparam int unsigned BIT_CNT_W          = 5;
   // Address register width (largest field)
   localparam int unsigned ADDR_W             = 9;
   // Data register width (largest word)
   localparam int unsigned DATA_W             = 16;
   // Serial output idle level after reset
   localparam logic        DOUT_RESET         = 1'b0;
   // Opcode encodings
   localparam logic [1:0]  OP_SPECIAL         = 2'h0;
   localparam logic [1:0]  OP_WRITE           = 2'h1;
   localparam logic [1:0]  OP_READ            = 2'h2;
   localparam logic [1:0]  OP_ERASE           = 2'h3;
   // Special sub-codes taken from the two top address bits
   localparam logic [1:0]  SUB_DISABLE        = 2'h0;
   localparam logic [1:0]  SUB_WRITE_ALL      = 2'h1;
   localparam logic [1:0]  SUB_ERASE_ALL      = 2'h2;
   localparam logic [1:0]  SUB_ENABLE         = 2'h3;

   // Command state machine
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_DATA,
      ST_READ_OUT,
      ST_DONE
   } cmd_state_t;

   // Decoded instruction
   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_READ,
      CMD_WRITE,
      CMD_ERASE,
      CMD_WRITE_ALL,
      CMD_ERASE_ALL,
      CMD_ENABLE,
      CMD_DISABLE
   } cmd_t;
endpackage : sel_clk_pkg

// File: core/pin_sync.sv
/*
 Two flip-flop synchroniser with rise and fall detection on the synced level.
 Assumes the input is asynchronous to clk; reset is synchronous, active high.
*/
`timescale 1ns/100ps
module pin_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Asynchronous pin
   input  wire logic pin,
   // Synchronised level and edges
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta_r;  // First stage, read only by the second
   logic sync_r;  // Second stage
   logic prev_r;  // Delayed copy for edge detection

   // Synchroniser chain and edge history
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise  = sync_r & ~prev_r;
   assign fall  = ~sync_r & prev_r;
endmodule : pin_sync

// File: core/word_fifo.sv
/*
 Flip-flop FIFO with valid/ready on both sides.
 Assumes one clock, synchronous active-high reset, DEPTH a power of two.
*/
`timescale 1ns/100ps
module word_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   // Flush discards all content
   input  wire logic             flush
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];  // Storage
   logic [AW-1:0]    wr_r;           // Write index
   logic [AW-1:0]    rd_r;           // Read index
   logic [AW:0]      cnt_r;          // Fill level
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_r[rd_r];

   // Storage writes
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   // Pointers and level; flush wins over any transfer
   always_ff @(posedge clk) begin
      if (rst || flush) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= rd_r + 1'b1;
         end
         cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule : word_fifo

// File: core/serial_front.sv
/*
 Select/clock front end of a three-wire serial memory slave.
 Assumes ref_clk at 250 MHz, far faster than the serial clock, and that
 the array side answers read requests with words through the FIFO.
*/
// Summary of operation
// - Select high means selected, low deselected
// - Ignore clock and data while deselected
// - Select rise returns command machine to idle
// - Select fall after program starts programming
// - Capture data-in on serial clock rise
// - Launch each output bit on clock rise
// - Long deselect raises deselect_done; it clears no register
// - Skip leading zeros until start one
// - Two-bit opcode plus top address picks command
// - Address eight bits x16, nine bits x8
// - Read sends zero dummy, then word MSB-first
`timescale 1ns/100ps
module serial_front
   import sel_clk_pkg::*;
#(
   parameter int unsigned FIFO_DEPTH = 32
) (
   // Core clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   // Serial pins from the master
   input  wire logic                     select_in,
   input  wire logic                     serial_clock_in,
   input  wire logic                     serial_data_in,
   input  wire logic                     word_width_select,
   // Serial data out pin (enable low while driving)
   output logic                          serial_data_out,
   output logic                          serial_data_oe_n,
   // Decoded instruction towards the array
   output logic                          cmd_valid,
   output sel_clk_pkg::cmd_t             cmd_code,
   output logic [sel_clk_pkg::ADDR_W-1:0] cmd_addr,
   output logic [sel_clk_pkg::DATA_W-1:0] cmd_data,
   output logic                          program_start,
   // Read words from the array
   input  wire logic                     rd_valid,
   output logic                          rd_ready,
   input  wire logic [sel_clk_pkg::DATA_W-1:0] rd_data,
   // Front end status
   output logic                          deselect_done
);
   import sel_clk_pkg::*;

   // Synchronised pins and edges
   logic                   sel_lvl;     // Synced select
   logic                   sel_rise;    // Select rising
   logic                   sel_fall;    // Select falling
   logic                   sk_rise;     // Serial clock rising
   logic                   di_lvl;      // Synced data in
   logic                   org_lvl;     // Synced word width

   // Frame decode and shift registers
   cmd_state_t             state_r;     // Command machine
   logic [BIT_CNT_W-1:0]   bit_cnt_r;   // Bits left in current field
   logic [OPCODE_W-1:0]    opcode_r;    // Opcode shift register
   logic [ADDR_W-1:0]      addr_r;      // Address shift register
   logic [DATA_W-1:0]      data_r;      // Data in shift register
   logic [DATA_W-1:0]      out_sh_r;    // Data out shift register
   logic                   x16_r;       // Word width held for the frame

   // Deselect timing and pin drivers
   logic [DESEL_CNT_W-1:0] desel_cnt_r; // Deselect time counter
   logic                   dout_r;      // Output bit register
   logic                   oe_n_r;      // Output enable register

   // Registered outputs to the array
   logic                   cmd_valid_r; // One-cycle command pulse
   cmd_t                   cmd_code_r;  // Last decoded command
   logic                   prog_r;      // Programming start pulse

   // Buffer, decoder and shifter glue
   logic                   load_word;   // FIFO word taken into out_sh_r
   logic                   fifo_valid;
   logic [DATA_W-1:0]      fifo_data;
   logic                   sk_edge;     // Usable clock rise in frame
   cmd_t                   dec;         // Decode of opcode and top address

   // Pin synchronisers
   pin_sync u_sel (.clk(ref_clk), .rst(rst), .pin(select_in),
                   .level(sel_lvl), .rise(sel_rise), .fall(sel_fall));

   // Serial clock; only its rise is used
   pin_sync u_sk  (.clk(ref_clk), .rst(rst), .pin(serial_clock_in),
                   .level(), .rise(sk_rise), .fall());

   // Data in, read at usable clock rises
   pin_sync u_di  (.clk(ref_clk), .rst(rst), .pin(serial_data_in),
                   .level(di_lvl), .rise(), .fall());

   // Word width, latched at select rise
   pin_sync u_org (.clk(ref_clk), .rst(rst), .pin(word_width_select),
                   .level(org_lvl), .rise(), .fall());

   // Read word buffer; the array fills it, the output shifter drains it
   word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(ref_clk), .rst(rst),
      .in_valid(rd_valid), .in_ready(rd_ready), .in_data(rd_data),
      .out_valid(fifo_valid), .out_ready(load_word), .out_data(fifo_data),
      .flush(sel_rise)
   );

   // Clock edges count only while selected and not on the select edge itself
   assign sk_edge = sk_rise & sel_lvl & ~sel_rise;

   // Instruction decode from opcode and top two address bits
   always_comb begin
      dec = CMD_NONE;
      case (opcode_r)
         OP_READ:  dec = CMD_READ;
         OP_WRITE: dec = CMD_WRITE;
         OP_ERASE: dec = CMD_ERASE;
         OP_SPECIAL: begin
            case (x16_r ? addr_r[7:6] : addr_r[8:7])
               SUB_DISABLE:   dec = CMD_DISABLE;
               SUB_WRITE_ALL: dec = CMD_WRITE_ALL;
               SUB_ERASE_ALL: dec = CMD_ERASE_ALL;
               SUB_ENABLE:    dec = CMD_ENABLE;
               default:       dec = CMD_NONE;
            endcase
         end
         default:  dec = CMD_NONE;
      endcase
   end

   // Word taken from the FIFO at the dummy bit of a read
   assign load_word = sk_edge && state_r == ST_ADDR && bit_cnt_r == 5'h1 &&
                      dec == CMD_READ;

   // Command state machine and field counter
   always_ff @(posedge ref_clk) begin
      if (rst || sel_rise || !sel_lvl) begin
         state_r   <= ST_IDLE;
         bit_cnt_r <= '0;
      end else if (sk_edge) begin
         case (state_r)
            // Zeros before the start bit are dropped
            ST_IDLE: begin
               if (di_lvl) begin
                  state_r   <= ST_OPCODE;
                  bit_cnt_r <= BIT_CNT_W'(OPCODE_W);
               end
            end
            // Two opcode bits, MSB first
            ST_OPCODE: begin
               if (bit_cnt_r == 5'h1) begin
                  state_r   <= ST_ADDR;
                  bit_cnt_r <= x16_r ? BIT_CNT_W'(ADDR_LEN_X16)
                                     : BIT_CNT_W'(ADDR_LEN_X8);
               end else begin
                  bit_cnt_r <= bit_cnt_r - 1'b1;
               end
            end
            // Last address bit picks the next phase
            ST_ADDR: begin
               if (bit_cnt_r == 5'h1) begin
                  bit_cnt_r <= x16_r ? BIT_CNT_W'(DATA_LEN_X16)
                                     : BIT_CNT_W'(DATA_LEN_X8);
                  if (dec_next_is_data()) begin
                     state_r <= ST_DATA;
                  end else if (dec_next_is_read()) begin
                     state_r <= ST_READ_OUT;
                  end else begin
                     state_r <= ST_DONE;
                  end
               end else begin
                  bit_cnt_r <= bit_cnt_r - 1'b1;
               end
            end
            // One bit per rise, in or out
            ST_DATA, ST_READ_OUT: begin
               if (bit_cnt_r == 5'h1) begin
                  state_r <= ST_DONE;
               end
               bit_cnt_r <= bit_cnt_r - 1'b1;
            end
            // Clocks past the frame end are ignored
            ST_DONE: state_r <= ST_DONE;
            // Unused codes return to idle
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // The last address bit is still arriving, so decode uses the shifted value
   function automatic logic [1:0] next_top();
      next_top = x16_r ? addr_r[6:5] : addr_r[7:6];
   endfunction : next_top

   // Write and write-all take a data word
   function automatic logic dec_next_is_data();
      dec_next_is_data = (opcode_r == OP_WRITE) ||
                         (opcode_r == OP_SPECIAL && next_top() == SUB_WRITE_ALL);
   endfunction : dec_next_is_data

   // Only a read drives the output
   function automatic logic dec_next_is_read();
      dec_next_is_read = (opcode_r == OP_READ);
   endfunction : dec_next_is_read

   // Field shift registers, captured on serial clock rise
   always_ff @(posedge ref_clk) begin
      if (rst || sel_rise) begin
         opcode_r <= '0;
         addr_r   <= '0;
         data_r   <= '0;
         x16_r    <= org_lvl;
      end else if (sk_edge) begin
         case (state_r)
            ST_OPCODE: opcode_r <= {opcode_r[0], di_lvl};
            ST_ADDR:   addr_r   <= {addr_r[ADDR_W-2:0], di_lvl};
            ST_DATA:   data_r   <= {data_r[DATA_W-2:0], di_lvl};
            default:   opcode_r <= opcode_r;
         endcase
      end
   end

   // Decoded command published when its frame is complete
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cmd_valid_r <= 1'b0;
         cmd_code_r  <= CMD_NONE;
      end else begin
         // Pulse for one cycle; the code stands
         cmd_valid_r <= 1'b0;
         if (sel_fall && state_r == ST_DONE) begin
            cmd_valid_r <= 1'b1;
            cmd_code_r  <= dec;
         end
      end
   end

   // Programming starts on the select fall of a programming frame
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prog_r <= 1'b0;
      end else begin
         prog_r <= sel_fall && state_r == ST_DONE &&
                   (dec == CMD_WRITE || dec == CMD_ERASE ||
                    dec == CMD_WRITE_ALL || dec == CMD_ERASE_ALL);
      end
   end

   // Output shifter: zero dummy then the word, MSB first, on clock rise
   always_ff @(posedge ref_clk) begin
      if (rst || !sel_lvl) begin
         // Deselected: idle level, shifter empty
         dout_r   <= DOUT_RESET;
         out_sh_r <= '0;
      end else if (load_word) begin
         // Dummy zero launched by the last address rise
         dout_r   <= 1'b0;
         // An empty buffer reads as a zero word
         if (!fifo_valid) begin
            out_sh_r <= '0;
         end else if (x16_r) begin
            out_sh_r <= fifo_data;
         end else begin
            out_sh_r <= {fifo_data[DATA_LEN_X8-1:0], 8'h00};
         end
      end else if (sk_edge && state_r == ST_READ_OUT) begin
         // One bit per usable clock rise
         dout_r   <= out_sh_r[DATA_W-1];
         out_sh_r <= {out_sh_r[DATA_W-2:0], 1'b0};
      end
   end

   // Output enable only while selected in a read's output or done phase; released within a few core cycles of fall
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         oe_n_r <= 1'b1;
      end else begin
         oe_n_r <= ~(sel_lvl & (state_r == ST_READ_OUT ||
                   (state_r == ST_DONE && opcode_r == OP_READ)));
      end
   end

   // Deselect timer: reports once select has stayed low long enough
   always_ff @(posedge ref_clk) begin
      if (rst || sel_lvl) begin
         desel_cnt_r <= '0;
      end else if (desel_cnt_r != DESEL_CNT_W'(DESELECT_MIN_CYC)) begin
         // Stops at the limit so the flag holds
         desel_cnt_r <= desel_cnt_r + 1'b1;
      end
   end

   // Serial pin
   assign serial_data_out  = dout_r;
   assign serial_data_oe_n = oe_n_r;

   // Array side
   assign cmd_valid        = cmd_valid_r;
   assign cmd_code         = cmd_code_r;
   assign cmd_addr         = addr_r;
   assign cmd_data         = data_r;
   assign program_start    = prog_r;

   // Status
   assign deselect_done    = (desel_cnt_r == DESEL_CNT_W'(DESELECT_MIN_CYC));
endmodule : serial_front

// File: testbench/serial_front_sva.sv
/*
 Checker for the serial front end: timing of data out, output enable,
 command pulses and the deselect interval, seen at the top ports.
 Assumes ref_clk at 250 MHz and pins that are synchronised inside the design.
*/
`timescale 1ns/100ps
module serial_front_sva
   import sel_clk_pkg::*;
(
   // Core clock and reset
   input wire logic               ref_clk,
   input wire logic               rst,
   // Serial pins
   input wire logic               select_in,
   input wire logic               serial_clock_in,
   input wire logic               serial_data_out,
   input wire logic               serial_data_oe_n,
   // Array side and status
   input wire logic               cmd_valid,
   input wire sel_clk_pkg::cmd_t  cmd_code,
   input wire logic               program_start,
   input wire logic               deselect_done
);
   logic       clk_q;     // Raw serial clock one cycle ago
   logic [7:0] rise_age;  // Cycles since the last raw clock rise
   logic [8:0] low_cnt;   // Cycles select has been low, saturating

   // Delay the raw serial clock for edge finding
   always_ff @(posedge ref_clk) begin
      clk_q <= serial_clock_in;
   end

   // Age of the last serial clock rise; saturates so it never wraps
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rise_age <= 8'hff;
      end else if (serial_clock_in && !clk_q) begin
         rise_age <= 8'h00;
      end else if (rise_age != 8'hff) begin
         rise_age <= rise_age + 8'h01;
      end
   end

   // Length of the present deselect interval
   always_ff @(posedge ref_clk) begin
      if (rst || select_in) begin
         low_cnt <= 9'h000;
      end else if (low_cnt != 9'h1ff) begin
         low_cnt <= low_cnt + 9'h001;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Select held low long enough for the synchroniser to see it
   sequence held_low;
      (!select_in)[*6];
   endsequence
   // Select steady high, so no frame start or end is near
   sequence sel_steady;
      select_in[*8];
   endsequence

   oe_hiz_a: assert property (held_low |-> serial_data_oe_n)
      else $error("data out enabled while deselected");
   oe_sel_a: assert property (!serial_data_oe_n |-> low_cnt <= 9'd6)
      else $error("data out enabled long after select fell");
   pulse_one_a: assert property (cmd_valid |=> !cmd_valid)
      else $error("command pulse longer than one cycle");
   prog_kind_a: assert property (program_start |-> cmd_valid && cmd_code inside
      {CMD_WRITE, CMD_ERASE, CMD_WRITE_ALL, CMD_ERASE_ALL})
      else $error("programming started for a non-programming command");
   cmd_at_fall_a: assert property (cmd_valid |-> !select_in && !$past(select_in, 2))
      else $error("command issued while still selected");
   desel_time_a: assert property ($rose(deselect_done) |->
      low_cnt >= 9'd248 && low_cnt <= 9'd258)
      else $error("deselect interval flagged at the wrong count");
   desel_clear_a: assert property (select_in[*5] |-> !deselect_done)
      else $error("deselect flag stays up while selected");
   dout_launch_a: assert property (sel_steady ##1 (select_in &&
      $changed(serial_data_out)) |-> rise_age <= 8'd6)
      else $error("data out changed without a serial clock rise");
endmodule : serial_front_sva

// File: testbench/ser_master.sv
/*
 Bus master model: drives select, serial clock, data in and word width,
 and samples data out. Assumes ref_clk at 250 MHz; the serial clock has a
 32 ns period and stands low between frames.
*/
`timescale 1ns/100ps
module ser_master (
   // Pacing clock
   input  wire logic ref_clk,
   // Pins towards the device
   output logic      select_in,
   output logic      serial_clock_in,
   output logic      serial_data_in,
   output logic      word_width_select,
   // Data out from the device
   input  wire logic serial_data_out,
   input  wire logic serial_data_oe_n
);
   logic do_pin; // Pin as seen; a released pin reads inverted
   assign do_pin = serial_data_oe_n ? ~serial_data_out : serial_data_out;

   // Idle pins at time zero
   initial begin
      select_in = 1'b0;
      serial_clock_in = 1'b0;
      serial_data_in = 1'b0;
      word_width_select = 1'b1;
   end

   // Half a serial clock period, changes just after a core edge
   task automatic half();
      repeat (4) @(posedge ref_clk);
      #1;
   endtask : half

   // Clock and data toggling while deselected, which must be ignored
   task automatic idle_clk(input int n);
      repeat (n) begin
         serial_data_in = ~serial_data_in;
         serial_clock_in = 1'b1;
         half();
         serial_clock_in = 1'b0;
         half();
      end
   endtask : idle_clk

   // One framed cycle: n bits of v MSB first, then nrd read rises
   task automatic frame(input logic w, input logic [31:0] v, input int n, input int nrd,
                        output logic [16:0] rd, output logic oe_ok);
      int i;
      oe_ok = 1'b1;
      rd = 17'h00000;
      word_width_select = w;
      half();
      select_in = 1'b1;
      half();
      half();
      for (i = n - 1; i >= 0; i--) begin
         serial_clock_in = 1'b0;
         serial_data_in = v[i];
         half();
         serial_clock_in = 1'b1;
         half();
      end
      // Sample just before each rise, so each launched bit has settled
      for (i = 0; i <= nrd && nrd > 0; i++) begin
         serial_clock_in = 1'b0;
         serial_data_in = ~serial_data_in;
         half();
         rd = {rd[15:0], do_pin};
         if (serial_data_oe_n !== 1'b0) oe_ok = 1'b0;
         if (i < nrd) begin
            serial_clock_in = 1'b1;
            half();
         end
      end
      serial_clock_in = 1'b0;
      half();
      select_in = 1'b0;
      serial_data_in = ~serial_data_in;
   endtask : frame
endmodule : ser_master

// File: testbench/tb_top.sv
/*
 Testbench for the serial front end: reads in both widths, every command,
 aborted frames and the deselect interval.
 Assumes the master model drives the pins and the bench feeds read words.
*/
`timescale 1ns/100ps
module tb_top;
   import sel_clk_pkg::*;
   logic              ref_clk, rst, select_in, serial_clock_in, serial_data_in;
   logic              word_width_select, serial_data_out, serial_data_oe_n;
   logic              cmd_valid, program_start, rd_valid, rd_ready, deselect_done;
   cmd_t              cmd_code, last_code;  // Live and last captured command
   logic [ADDR_W-1:0] cmd_addr, last_addr;
   logic [DATA_W-1:0] cmd_data, last_data, rd_data;
   logic [16:0]       rd;                   // Samples from a read
   logic              ok;                   // Output enable held during read
   int                n_fail, compares, n_cmd, n_prog, cycles;

   serial_front #(.FIFO_DEPTH(32)) serial_front_inst (.ref_clk, .rst, .select_in,
      .serial_clock_in, .serial_data_in, .word_width_select, .serial_data_out,
      .serial_data_oe_n, .cmd_valid, .cmd_code, .cmd_addr, .cmd_data, .program_start,
      .rd_valid, .rd_ready, .rd_data, .deselect_done);
   ser_master ser_master_inst (.ref_clk, .select_in, .serial_clock_in, .serial_data_in,
      .word_width_select, .serial_data_out, .serial_data_oe_n);

   // Core clock, 4 ns period
   initial ref_clk = 1'b0;
   always #2 ref_clk = ~ref_clk;

   // Capture command pulses and cut a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (cmd_valid === 1'b1) begin
         n_cmd++;
         last_code = cmd_code;
         last_addr = cmd_addr;
         last_data = cmd_data;
      end
      if (program_start === 1'b1) n_prog++;
      if (cycles == 40000) begin
         n_fail++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Deselect gap: flag still low before the interval, high after it
   task automatic rest();
      repeat (200) @(posedge ref_clk);
      #1;
      chk(deselect_done, 1'b0);
      chk(serial_data_oe_n, 1'b1);
      chk(rd_ready, 1'b0);
      repeat (60) @(posedge ref_clk);
      #1;
      chk(deselect_done, 1'b1);
   endtask : rest

   // Read with leading zeros; dummy zero then the word MSB first
   task automatic t_read(input logic w, input logic [8:0] a, input logic [15:0] word);
      int na, nd, c0;
      na = w ? 8 : 9;
      nd = w ? 16 : 8;
      c0 = n_cmd;
      rd_data = word;
      ser_master_inst.frame(w, (32'h6 << na) | a, 6 + na, nd, rd, ok);
      rest();
      chk(ok, 1'b1);
      chk(rd[nd], 1'b0);
      chk(rd[15:0] & ((1 << nd) - 1), word & ((1 << nd) - 1));
      chk(n_cmd - c0, 1);
      chk(last_code, CMD_READ);
      chk(last_addr & ((1 << na) - 1), a & ((1 << na) - 1));
   endtask : t_read

   // Every other command in turn, both widths
   task automatic t_cmds();
      logic [1:0]  ops [6] = '{OP_WRITE, OP_ERASE, OP_SPECIAL, OP_SPECIAL, OP_SPECIAL, OP_SPECIAL};
      logic [1:0]  tops [6] = '{2'h2, 2'h1, SUB_WRITE_ALL, SUB_ERASE_ALL, SUB_ENABLE, SUB_DISABLE};
      cmd_t        ex [6] = '{CMD_WRITE, CMD_ERASE, CMD_WRITE_ALL, CMD_ERASE_ALL,
                              CMD_ENABLE, CMD_DISABLE};
      logic [31:0] v;
      logic [8:0]  a;
      int          i, na, nd, c0, p0;
      for (i = 0; i < 6; i++) begin
         na = i[0] ? 8 : 9;
         a = i[0] ? {1'b0, tops[i], 6'h15} : {tops[i], 7'h2a};
         nd = (i == 0 || i == 2) ? (i[0] ? 16 : 8) : 0;
         v = (((32'h1 << 2) | ops[i]) << na) | a;
         v = (v << nd) | (32'hc35a & ((1 << nd) - 1));
         c0 = n_cmd;
         p0 = n_prog;
         ser_master_inst.frame(i[0], v, 3 + na + nd, 0, rd, ok);
         rest();
         chk(n_cmd - c0, 1);
         chk(last_code, ex[i]);
         chk(n_prog - p0, (i < 4) ? 1 : 0);
         if (i < 2) chk(last_addr & ((1 << na) - 1), a);
         if (nd > 0) chk(last_data & ((1 << nd) - 1), 32'hc35a & ((1 << nd) - 1));
      end
   endtask : t_cmds

   // Traffic while deselected, a cut frame, then a fresh one
   task automatic t_abort();
      int c0, p0;
      c0 = n_cmd;
      p0 = n_prog;
      ser_master_inst.idle_clk(12);
      ser_master_inst.frame(1'b1, 32'h533, 11, 0, rd, ok);
      rest();
      chk(n_cmd - c0, 0);
      chk(n_prog - p0, 0);
      ser_master_inst.frame(1'b1, 32'h7c3, 11, 0, rd, ok);
      rest();
      chk(n_cmd - c0, 1);
      chk(last_code, CMD_ERASE);
      chk(n_prog - p0, 1);
   endtask : t_abort

   task automatic close_out();
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out

   // Main sequence
   initial begin
      rst = 1'b1;
      rd_valid = 1'b1;
      rd_data = 16'h0000;
      repeat (4) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      rest();
      t_read(1'b1, 9'h0a5, 16'hb3c1);
      t_read(1'b0, 9'h15a, 16'h006d);
      t_cmds();
      t_abort();
      t_read(1'b1, 9'h0ff, 16'h8001);
      close_out();
   end
endmodule : tb_top

bind serial_front serial_front_sva serial_front_sva_inst (.ref_clk, .rst, .select_in,
   .serial_clock_in, .serial_data_out, .serial_data_oe_n, .cmd_valid, .cmd_code,
   .program_start, .deselect_done);
